// ### rtl/fpc_pipe_ctrl.sv
// five-stage interlocked pipeline control with data bus mode and id capture
// Notes on behaviour
// - instructions flow in order through fetch, decode, execute, memory, write-back
// - hazards are found in hardware; timing changes only run time, never results
// - use of the preceding load's destination costs exactly one stall cycle
// - on a data abort the base register gets back its pre-instruction value
// - a direct store of the program counter writes its own address plus 12
// - wide opcodes with bits 27..25 equal 011 and bit 4 set are undefined
// - unassigned opcodes in the four extension spaces are undefined
// - an input picks one two-way data bus or separate write and read buses
// - identification returns the value present on the identification input
// - wide and compressed instruction sets both run, chosen by processor state
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_pipe_ctrl (
  input  logic              clk,
  input  logic              rst_n,
  input  logic              instr_valid,
  input  fpc_pkg::fpc_word_t instr_word,
  input  logic              compressed_state,
  input  fpc_pkg::fpc_word_t rn_value,
  input  fpc_pkg::fpc_word_t rd_value,
  input  logic              data_abort,
  input  logic              unidirectional_bus_select,
  input  fpc_pkg::fpc_word_t data_read_bus,
  input  fpc_pkg::fpc_word_t bidir_data_in,
  input  fpc_pkg::fpc_word_t identification_code_input,
  input  logic              id_req,
  output fpc_pkg::fpc_word_t fetch_addr,
  output logic              fetch_hold,
  output fpc_pkg::fpc_ridx_t rf_rn_idx,
  output fpc_pkg::fpc_ridx_t rf_rd_idx,
  output logic              data_req,
  output logic              data_write,
  output fpc_pkg::fpc_word_t data_addr,
  output fpc_pkg::fpc_word_t data_write_bus,
  output fpc_pkg::fpc_word_t bidir_data_out,
  output logic              bidir_data_oe_n,
  output logic              base_wr_en,
  output fpc_pkg::fpc_ridx_t base_wr_idx,
  output fpc_pkg::fpc_word_t base_wr_val,
  output logic              ld_en,
  output fpc_pkg::fpc_ridx_t ld_idx,
  output fpc_pkg::fpc_word_t ld_val,
  output logic              undef_exc,
  output logic              abort_taken,
  output fpc_pkg::fpc_word_t id_value
);
  import fpc_pkg::*;

  // ==========================================================
  // hazard check
  function automatic logic load_use(input fpc_stage_s e, input fpc_stage_s d);
    load_use = e.v && e.d.load && d.v &&
               ((d.d.uses_rn && d.d.rn == e.d.rd) ||
                (d.d.uses_rm && d.d.rm == e.d.rd) ||
                (d.d.uses_rd && d.d.rd == e.d.rd));
  endfunction

  // ==========================================================
  // pin synchronisers, three stages, second and third must agree
  logic      uni_s1_reg, uni_s2_reg, uni_s3_reg, uni_reg;
  fpc_word_t id_s1_reg, id_s2_reg, id_s3_reg, id_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uni_s1_reg <= 1'b0;
      uni_s2_reg <= 1'b0;
      uni_s3_reg <= 1'b0;
      uni_reg    <= 1'b0;
      id_s1_reg  <= '0;
      id_s2_reg  <= '0;
      id_s3_reg  <= '0;
      id_reg     <= '0;
    end else begin
      uni_s1_reg <= unidirectional_bus_select;
      uni_s2_reg <= uni_s1_reg;
      uni_s3_reg <= uni_s2_reg;
      // a level still settling is not yet taken
      if (uni_s2_reg == uni_s3_reg) begin
        uni_reg <= uni_s3_reg;
      end
      id_s1_reg <= identification_code_input;
      id_s2_reg <= id_s1_reg;
      id_s3_reg <= id_s2_reg;
      if (id_s2_reg == id_s3_reg) begin
        id_reg <= id_s3_reg;
      end
    end
  end

  // ==========================================================
  // pipeline next state
  fpc_dec_if dif ();
  fpc_decoder u_dec (.dif(dif));

  fpc_word_t  pc_reg, pc_next;
  fpc_stage_s d_reg, d_next, e_reg, e_next, m_reg, m_next;
  logic       hold_reg, hold_next, oe_n_reg, oe_n_next;
  logic       bwe_reg, bwe_next, lde_reg, lde_next;
  fpc_ridx_t  bwi_reg, bwi_next, ldi_reg, ldi_next;
  fpc_word_t  bwv_reg, bwv_next, ldv_reg, ldv_next;
  logic       und_reg, und_next, abt_reg, abt_next;
  fpc_word_t  idv_reg, idv_next;
  logic       stall, undef_now, abort_now, flush, take;

  always_comb begin
    fpc_word_t off;
    off = '0;
    dif.word = instr_word;
    dif.cset = compressed_state;
    stall = load_use(e_reg, d_reg);
    undef_now = e_reg.v & e_reg.d.undef;
    abort_now = m_reg.acc & data_abort;
    // younger work is dropped behind an exception
    flush = undef_now | abort_now;
    take = instr_valid & ~stall & ~flush;
    pc_next = pc_reg;
    if (take) begin
      pc_next = pc_reg + (compressed_state ? `FPC_SHORT_STEP : `FPC_WIDE_STEP);
    end
    // fetch to decode
    d_next = d_reg;
    if (!stall) begin
      d_next = '0;
      if (take) begin
        d_next.v = 1'b1;
        d_next.cset = compressed_state;
        d_next.pc = pc_reg;
        d_next.d = dif.dec;
      end
    end
    if (flush) begin
      d_next.v = 1'b0;
    end
    // decode to execute, a bubble while stalled
    e_next = '0;
    if (!stall && !flush) begin
      e_next = d_reg;
      e_next.base = rn_value;
      e_next.sdata = rd_value;
    end
    // execute to memory
    off = {20'h00000, e_reg.d.off};
    m_next = e_reg;
    m_next.v = e_reg.v & ~flush;
    m_next.nbase = e_reg.d.up ? e_reg.base + off : e_reg.base - off;
    m_next.addr = e_reg.d.pre ? m_next.nbase : e_reg.base;
    if (e_reg.d.store && e_reg.d.rd == `FPC_PC_IDX && !e_reg.cset) begin
      m_next.sdata = e_reg.pc + `FPC_PC_STORE_OFS;
    end
    m_next.acc = m_next.v & (e_reg.d.load | e_reg.d.store);
    m_next.wr = m_next.v & e_reg.d.store;
    // the two-way bus is only driven for a write in that mode
    oe_n_next = ~(m_next.wr & ~uni_reg);
    // memory to write-back
    bwe_next = m_reg.acc & m_reg.d.wb;
    bwi_next = m_reg.d.rn;
    bwv_next = abort_now ? m_reg.base : m_reg.nbase;
    lde_next = m_reg.acc & m_reg.d.load & ~abort_now;
    ldi_next = m_reg.d.rd;
    ldv_next = uni_reg ? data_read_bus : bidir_data_in;
    und_next = undef_now;
    abt_next = abort_now;
    hold_next = load_use(e_next, d_next);
    idv_next = id_req ? id_reg : idv_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg   <= `FPC_RESET_PC;
      d_reg    <= '0;
      e_reg    <= '0;
      m_reg    <= '0;
      hold_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      bwe_reg  <= 1'b0;
      bwi_reg  <= '0;
      bwv_reg  <= '0;
      lde_reg  <= 1'b0;
      ldi_reg  <= '0;
      ldv_reg  <= '0;
      und_reg  <= 1'b0;
      abt_reg  <= 1'b0;
      idv_reg  <= '0;
    end else begin
      pc_reg   <= pc_next;
      d_reg    <= d_next;
      e_reg    <= e_next;
      m_reg    <= m_next;
      hold_reg <= hold_next;
      oe_n_reg <= oe_n_next;
      bwe_reg  <= bwe_next;
      bwi_reg  <= bwi_next;
      bwv_reg  <= bwv_next;
      lde_reg  <= lde_next;
      ldi_reg  <= ldi_next;
      ldv_reg  <= ldv_next;
      und_reg  <= und_next;
      abt_reg  <= abt_next;
      idv_reg  <= idv_next;
    end
  end

  assign fetch_addr      = pc_reg;
  assign fetch_hold      = hold_reg;
  assign rf_rn_idx       = d_reg.d.rn;
  assign rf_rd_idx       = d_reg.d.rd;
  assign data_req        = m_reg.acc;
  assign data_write      = m_reg.wr;
  assign data_addr       = m_reg.addr;
  assign data_write_bus  = m_reg.sdata;
  assign bidir_data_out  = m_reg.sdata;
  assign bidir_data_oe_n = oe_n_reg;
  assign base_wr_en      = bwe_reg;
  assign base_wr_idx     = bwi_reg;
  assign base_wr_val     = bwv_reg;
  assign ld_en           = lde_reg;
  assign ld_idx          = ldi_reg;
  assign ld_val          = ldv_reg;
  assign undef_exc       = und_reg;
  assign abort_taken     = abt_reg;
  assign id_value        = idv_reg;

  // ==========================================================
  // checks
  a_stage_order: assert property (@(posedge clk) disable iff (!rst_n)
    e_reg.v && !flush |=> m_reg.v && m_reg.pc == $past(e_reg.pc))
    else $error("execute did not advance into memory stage");
  a_stall_flag: assert property (@(posedge clk) disable iff (!rst_n)
    fetch_hold == stall)
    else $error("hold output disagrees with hazard");
  a_one_stall: assert property (@(posedge clk) disable iff (!rst_n)
    stall && !flush |=> !stall)
    else $error("load-use stall lasted more than one cycle");
  a_stall_bubble: assert property (@(posedge clk) disable iff (!rst_n)
    stall && !flush |=> !e_reg.v && d_reg == $past(d_reg))
    else $error("stall lost or duplicated an instruction");
  a_base_restore: assert property (@(posedge clk) disable iff (!rst_n)
    abort_now && m_reg.d.wb |=> base_wr_en && base_wr_val == $past(m_reg.base)
      && !ld_en && abort_taken)
    else $error("aborted access did not restore base");
  a_pc_store: assert property (@(posedge clk) disable iff (!rst_n)
    e_reg.v && !flush && e_reg.d.store && !e_reg.cset && e_reg.d.rd == `FPC_PC_IDX
      |=> data_write && data_write_bus == $past(e_reg.pc) + `FPC_PC_STORE_OFS)
    else $error("stored program counter is not address plus 12");
  a_undef_space: assert property (@(posedge clk) disable iff (!rst_n)
    !compressed_state && instr_word[27:25] == `FPC_UNDEF_OP && instr_word[4]
      |-> dif.dec.undef)
    else $error("undefined space not decoded as undefined");
  a_ext_space: assert property (@(posedge clk) disable iff (!rst_n)
    !compressed_state && instr_word[27:24] == 4'h0 && instr_word[7:4] == `FPC_MULT_SIG
      && instr_word[23:22] == 2'h1 |-> dif.dec.undef)
    else $error("unassigned arithmetic extension not undefined");
  a_undef_raise: assert property (@(posedge clk) disable iff (!rst_n)
    undef_now |=> undef_exc && !m_reg.v)
    else $error("undefined opcode did not raise exception");
  a_bus_drive: assert property (@(posedge clk) disable iff (!rst_n)
    !bidir_data_oe_n |-> data_write && !$past(uni_reg))
    else $error("two-way bus driven outside a write");
  a_read_mux: assert property (@(posedge clk) disable iff (!rst_n)
    m_reg.acc && m_reg.d.load && !abort_now |=> ld_en &&
      ld_val == ($past(uni_reg) ? $past(data_read_bus) : $past(bidir_data_in)))
    else $error("load data taken from wrong bus");
  a_id_value: assert property (@(posedge clk) disable iff (!rst_n)
    id_req |=> id_value == $past(id_reg))
    else $error("identification value not captured");
  a_fetch_step: assert property (@(posedge clk) disable iff (!rst_n)
    take |=> fetch_addr == $past(pc_reg)
      + ($past(compressed_state) ? `FPC_SHORT_STEP : `FPC_WIDE_STEP))
    else $error("fetch address step wrong for processor state");
endmodule

// ### pkg/fpc_map.svh
// offsets, positions, reset values and opcode patterns of the pipeline control block
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
`define FPC_RESET_PC     32'h0000_0000
`define FPC_WIDE_STEP    32'h0000_0004
`define FPC_SHORT_STEP   32'h0000_0002
`define FPC_PC_STORE_OFS 32'h0000_000C
`define FPC_PC_IDX       4'hF
`define FPC_UNDEF_OP     3'h3
`define FPC_MULT_SIG     4'h9
`define FPC_SHORT_UNDEF  8'hDE
`endif

// ### pkg/fpc_pkg.sv
// types shared by the pipeline control block and its decoder
package fpc_pkg;
  typedef logic [31:0] fpc_word_t;
  typedef logic [3:0]  fpc_ridx_t;

  typedef struct packed {
    logic       undef;
    logic       load;
    logic       store;
    logic       wb;
    logic       up;
    logic       pre;
    logic       uses_rn;
    logic       uses_rm;
    logic       uses_rd;
    fpc_ridx_t  rn;
    fpc_ridx_t  rd;
    fpc_ridx_t  rm;
    logic [11:0] off;
  } fpc_dec_s;

  typedef struct packed {
    logic      v;
    logic      cset;
    logic      acc;
    logic      wr;
    fpc_word_t pc;
    fpc_word_t base;
    fpc_word_t nbase;
    fpc_word_t addr;
    fpc_word_t sdata;
    fpc_dec_s  d;
  } fpc_stage_s;
endpackage

// ### pkg/fpc_dec_if.sv
// carrier between the pipeline control and the instruction decoder
`timescale 1ns/1ps
interface fpc_dec_if;
  fpc_pkg::fpc_word_t word;
  logic               cset;
  fpc_pkg::fpc_dec_s  dec;
  modport decoder (input word, input cset, output dec);
  modport user    (output word, output cset, input dec);
endinterface

// ### rtl/fpc_decoder.sv
// instruction decoder for both instruction sets, with undefined spaces
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_decoder (
  fpc_dec_if.decoder dif
);
  import fpc_pkg::*;

  always_comb begin
    fpc_word_t w;
    logic      ctrl_ok;
    w = dif.word;
    ctrl_ok = 1'b0;
    dif.dec = '0;
    if (!dif.cset) begin
      // ======================================================
      // wide set
      dif.dec.rn = w[19:16];
      dif.dec.rd = w[15:12];
      dif.dec.rm = w[3:0];
      dif.dec.up = w[23];
      dif.dec.pre = w[24];
      if (w[27:25] == `FPC_UNDEF_OP && w[4]) begin
        dif.dec.undef = 1'b1;
      end else if (w[27:26] == 2'h1) begin
        dif.dec.load = w[20];
        dif.dec.store = ~w[20];
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rm = w[25];
        dif.dec.uses_rd = ~w[20];
        dif.dec.wb = ~w[24] | w[21];
        dif.dec.off = w[25] ? 12'h000 : w[11:0];
      end else if (w[27:21] == 7'h60) begin
        dif.dec.undef = 1'b1;
      end else if (w[27:24] == 4'h0 && w[7:4] == `FPC_MULT_SIG) begin
        dif.dec.undef = (w[23:22] == 2'h1);
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rm = 1'b1;
      end else if (w[27:24] == 4'h1 && w[7:4] == `FPC_MULT_SIG) begin
        // swap is the only assigned form here
        dif.dec.undef = ~(~w[23] && w[21:20] == 2'h0 && w[11:8] == 4'h0);
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rm = 1'b1;
      end else if (w[27:25] == 3'h0 && w[7] && w[4]) begin
        // signed forms only exist as loads
        dif.dec.undef = w[6] & ~w[20];
        dif.dec.load = w[20];
        dif.dec.store = ~w[20];
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rm = ~w[22];
        dif.dec.uses_rd = ~w[20];
        dif.dec.wb = ~w[24] | w[21];
        dif.dec.off = w[22] ? {4'h0, w[11:8], w[3:0]} : 12'h000;
      end else if (w[27:23] == 5'h02 && !w[20]) begin
        ctrl_ok = (!w[25] && w[7:4] == 4'h0)
                | (!w[25] && w[7:4] == 4'h1 && w[22:21] == 2'h1)
                | (w[25] && w[21]);
        dif.dec.undef = ~ctrl_ok;
        dif.dec.uses_rm = ~w[25];
      end else if (w[27:26] == 2'h0) begin
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rm = ~w[25];
      end
    end else begin
      // ======================================================
      // compressed set, low half of the word
      dif.dec.rn = {1'b0, w[5:3]};
      dif.dec.rd = {1'b0, w[2:0]};
      dif.dec.rm = {1'b0, w[8:6]};
      dif.dec.up = 1'b1;
      dif.dec.pre = 1'b1;
      if (w[15:8] == `FPC_SHORT_UNDEF) begin
        dif.dec.undef = 1'b1;
      end else if (w[15:13] == 3'h3) begin
        dif.dec.load = w[11];
        dif.dec.store = ~w[11];
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rd = ~w[11];
        dif.dec.off = w[12] ? {7'h00, w[10:6]} : {5'h00, w[10:6], 2'h0};
      end else if (w[15:11] == 5'h03) begin
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rm = ~w[10];
      end else if (w[15:10] == 6'h10) begin
        dif.dec.rn = {1'b0, w[2:0]};
        dif.dec.rm = {1'b0, w[5:3]};
        dif.dec.uses_rn = 1'b1;
        dif.dec.uses_rm = 1'b1;
      end
    end
  end
endmodule

// ### tb/fpc_mem_model.sv
// data memory partner: single-cycle answers, optional abort at one address
`timescale 1ns/1ps
module fpc_mem_model (
  input  logic               clk,
  input  logic               data_req,
  input  logic               data_write,
  input  fpc_pkg::fpc_word_t data_addr,
  input  fpc_pkg::fpc_word_t bidir_data_out,
  input  logic               bidir_data_oe_n,
  input  logic               unidirectional_bus_select,
  input  logic               abort_en,
  input  fpc_pkg::fpc_word_t abort_addr,
  output fpc_pkg::fpc_word_t data_read_bus,
  output fpc_pkg::fpc_word_t bidir_data_in,
  output logic               data_abort
);
  import fpc_pkg::*;
  // ====
  // memory answers
  fpc_word_t last_reg = 32'h0000_0000;
  fpc_word_t rd_word;
  logic      rd;
  assign rd_word = data_addr ^ 32'hC3C3_0000;
  assign rd = data_req & ~data_write;
  // an unselected bus shows the inverse of the last word read on either bus, never a stale copy
  assign data_read_bus = (rd & unidirectional_bus_select) ? rd_word : ~last_reg;
  assign bidir_data_in = !bidir_data_oe_n ? bidir_data_out :
                         (rd & ~unidirectional_bus_select) ? rd_word : ~last_reg;
  assign data_abort = data_req & abort_en & (data_addr === abort_addr);
  always @(posedge clk) begin
    if (rd) begin
      last_reg <= rd_word;
    end
  end
endmodule

// ### tb/five_stage_core_pipeline_ctrl_tb_top.sv
// testbench for the pipeline control block
`timescale 1ns/1ps
module five_stage_core_pipeline_ctrl_tb_top;
  import fpc_pkg::*;
  // ====
  // signals
  // filler reads only r11, so it never meets a load into r0 or r1
  localparam fpc_word_t NOP = 32'hE18B_B00B;
  localparam fpc_word_t MSK = 32'hC3C3_0000;
  logic clk = 0, rst_n = 0, instr_valid = 0, compressed_state = 0, abort_en = 0;
  logic id_req = 0, uni = 0, data_abort, fetch_hold, data_req, data_write;
  logic bidir_data_oe_n, base_wr_en, ld_en, undef_exc, abort_taken;
  fpc_word_t instr_word = NOP, abort_addr = 32'h0000_0000;
  fpc_word_t id_in = 32'h5A5A_1234; // arbitrary identification value
  fpc_word_t rn_value, rd_value, data_read_bus, bidir_data_in, fetch_addr, data_addr;
  fpc_word_t data_write_bus, bidir_data_out, base_wr_val, ld_val, id_value;
  fpc_ridx_t rf_rn_idx, rf_rd_idx, base_wr_idx, ld_idx;
  int num_errors = 0, samples_checked = 0, stalls = 0, ld_cnt = 0, ab_cnt = 0, ud_cnt = 0;
  fpc_word_t ldv_c, bw_c, st_c, bo_c, da_c, fa;
  fpc_ridx_t ldi_c, bwi_c;
  logic oe_c;
  // register file stand-in: value tells which index was read
  assign rn_value = {24'h0000_10, rf_rn_idx, 4'h0};
  assign rd_value = {28'h5500_000, rf_rd_idx};
  initial forever #10 clk = ~clk;
  fpc_pipe_ctrl i_fpc_pipe_ctrl (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .compressed_state(compressed_state), .rn_value(rn_value),
    .rd_value(rd_value), .data_abort(data_abort), .unidirectional_bus_select(uni),
    .data_read_bus(data_read_bus), .bidir_data_in(bidir_data_in),
    .identification_code_input(id_in), .id_req(id_req), .fetch_addr(fetch_addr),
    .fetch_hold(fetch_hold), .rf_rn_idx(rf_rn_idx), .rf_rd_idx(rf_rd_idx),
    .data_req(data_req), .data_write(data_write), .data_addr(data_addr),
    .data_write_bus(data_write_bus), .bidir_data_out(bidir_data_out),
    .bidir_data_oe_n(bidir_data_oe_n), .base_wr_en(base_wr_en), .base_wr_idx(base_wr_idx),
    .base_wr_val(base_wr_val), .ld_en(ld_en), .ld_idx(ld_idx), .ld_val(ld_val),
    .undef_exc(undef_exc), .abort_taken(abort_taken), .id_value(id_value));
  fpc_mem_model i_fpc_mem_model (.clk(clk), .data_req(data_req), .data_write(data_write),
    .data_addr(data_addr), .bidir_data_out(bidir_data_out),
    .bidir_data_oe_n(bidir_data_oe_n), .unidirectional_bus_select(uni),
    .abort_en(abort_en), .abort_addr(abort_addr), .data_read_bus(data_read_bus),
    .bidir_data_in(bidir_data_in), .data_abort(data_abort));
  // ====
  // mid-cycle monitor: every output stands one cycle, so sample once per cycle
  always @(negedge clk) begin
    if (ld_en === 1'b1) begin
      ld_cnt++;
      ldi_c = ld_idx;
      ldv_c = ld_val;
    end
    if (base_wr_en === 1'b1) begin
      bw_c = base_wr_val;
      bwi_c = base_wr_idx;
    end
    if (undef_exc === 1'b1) ud_cnt++;
    if (abort_taken === 1'b1) ab_cnt++;
    if (data_req === 1'b1) da_c = data_addr;
    if (data_req === 1'b1 && data_write === 1'b1) begin
      st_c = data_write_bus;
      bo_c = bidir_data_out;
      oe_c = bidir_data_oe_n;
    end
  end
  // ====
  // helpers
  task automatic check(input fpc_word_t seen, input fpc_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // valid stays up between words, so it is never lowered and raised in one step
  task automatic feed(input fpc_word_t w, input logic th);
    int n;
    instr_valid = 1'b1;
    instr_word = w;
    compressed_state = th;
    fa = fetch_addr;
    for (n = 0; n < 8 && fetch_hold !== 1'b0; n++) begin
      stalls++;
      @(negedge clk);
      fa = fetch_addr;
    end
    if (n == 8) begin
      num_errors++;
      final_report();
    end
    @(negedge clk);
  endtask
  task automatic drain(input int k);
    repeat (k) feed(NOP, 1'b0);
  endtask
  // ====
  // scenarios
  task automatic s_load_use();
    fpc_word_t f0;
    f0 = fetch_addr;
    stalls = 0;
    ld_cnt = 0;
    feed(32'hE597_0000, 1'b0);
    feed(32'hE080_5001, 1'b0);
    drain(6);
    check(stalls, 1);
    check(fetch_addr - f0, 32'h20);
    check(ld_cnt, 1);
    check({28'h0, ldi_c}, 0);
    check(ldv_c, 32'h1070 ^ MSK);
    stalls = 0;
    feed(32'hE597_0000, 1'b0);
    feed(NOP, 1'b0);
    feed(32'hE080_5001, 1'b0);
    drain(6);
    check(stalls, 0);
  endtask
  task automatic s_store_pc(input logic exp_oe);
    fpc_word_t sa;
    feed(32'hE582_F000, 1'b0);
    sa = fa;
    drain(6);
    check(st_c, sa + 32'h0000_000C);
    check(bo_c, sa + 32'h0000_000C);
    check({31'h0, oe_c}, {31'h0, exp_oe});
    check(da_c, 32'h1020);
  endtask
  task automatic s_abort();
    abort_addr = 32'h1024;
    abort_en = 1'b1;
    ld_cnt = 0;
    ab_cnt = 0;
    feed(32'hE5B2_1004, 1'b0);
    drain(6);
    abort_en = 1'b0;
    check(ab_cnt, 1);
    check(ld_cnt, 0);
    check(bw_c, 32'h1020);
    check({28'h0, bwi_c}, 32'h2);
  endtask
  task automatic s_undef();
    fpc_word_t w[5] = '{32'hE600_0010, 32'hE040_0090, 32'h0000_DE00, 32'hE600_0000,
                        32'h0000_4600};
    logic th[5] = '{0, 0, 1, 0, 1};
    int e[5] = '{1, 1, 1, 0, 0};
    for (int i = 0; i < 5; i++) begin
      ud_cnt = 0;
      feed(w[i], th[i]);
      drain(6);
      check(ud_cnt, e[i]);
    end
  endtask
  task automatic s_unidir();
    uni = 1'b1;
    repeat (8) @(negedge clk);
    feed(32'hE597_0000, 1'b0);
    drain(6);
    check(ldv_c, 32'h1070 ^ MSK);
    s_store_pc(1'b1);
  endtask
  task automatic s_id(input fpc_word_t v);
    id_in = v;
    repeat (8) @(negedge clk);
    id_req = 1'b1;
    @(negedge clk);
    id_req = 1'b0;
    check(id_value, v);
  endtask
  // ====
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    check({31'h0, bidir_data_oe_n}, 1);
    check(fetch_addr, 32'h0000_0000);
    rst_n = 1'b1;
    drain(2);
    s_load_use();
    s_store_pc(1'b0);
    s_abort();
    s_undef();
    s_unidir();
    s_id(32'h5A5A_1234);
    s_id(32'h0F0F_A5C3);
    final_report();
  end
  initial begin
    #(20 * 20000);
    num_errors++;
    final_report();
  end
endmodule
